/* File: src/somm_pkg.sv */
package somm_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_SWITCH_STATE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL      = 8'h04;
    localparam logic [7:0] ADDR_CONFIG       = 8'h08;
    localparam logic [7:0] ADDR_STATUS       = 8'h0c;
    localparam logic [7:0] ADDR_POS_DIR      = 8'h10;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_SWITCH_STATE = 8'h00;
    localparam logic [1:0] RST_CONTROL      = 2'h1;
    localparam logic [7:0] RST_OUTPUTS      = 8'h00;
    localparam logic [7:0] CFG_DEFAULT      = 8'h0a;

    // ==========================================================
    // control register fields
    localparam int CTL_BACKCOMPAT = 0;
    localparam int CTL_STANDBY    = 1;

    // switch state / output bit positions
    localparam int SW_BAND    = 0;
    localparam int SW_POL     = 1;
    localparam int SW_POS     = 2;
    localparam int SW_OPTION  = 3;
    localparam int SW_COUNT   = 8;
    localparam int COMMITTED  = 4;

    // output configuration byte fields
    localparam int CFG_TONE_USE = 0;
    localparam int CFG_DEC_LSB  = 1;
    localparam int CFG_COMPL    = 5;
    localparam int CFG_TWO_LINE = 6;

    // status register fields
    localparam int ST_STANDBY  = 8;
    localparam int ST_POS_DRV  = 9;
    localparam int ST_POS_PIN  = 10;
    localparam int ST_MODE_LSB = 11;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_DECODED,
        MODE_COMPLEMENTARY
    } somm_mode_e;

    typedef struct packed {
        logic       two_line;
        logic       complementary;
        logic [3:0] decoded_number;
        logic       tone_use;
    } somm_cfg_s;

    typedef struct packed {
        logic [3:0] uncommitted;
        logic       switch_option;
        logic       position_b_a;
        logic       polarization;
        logic       band_high_low;
    } somm_switch_s;

endpackage

/* File: src/somm_output_mapper.sv */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - eight switching outputs plus one standby output
// - outputs one-four committed, five-eight uncommitted
// - exactly one of three output modes active
// - single polarity: each output follows its switch
// - decoded: three adjacent lines give one-of-eight
// - two-line decode gives one-of-four on outputs
// - complementary: uncommitted outputs invert committed ones
// - backward mode tone drives band or position
// - configuration from factory parameters, never pins
// - standby output only when option enabled
// - reset returns position pin to pulled-up input
// - external reset input is active low
// - low-voltage detector holds reset, enabled default
// - no decoded or complementary means single polarity
module somm_output_mapper
    import somm_pkg::*;
#(
    parameter logic [7:0] OUTPUT_CONFIG = somm_pkg::CFG_DEFAULT,
    parameter bit         STANDBY_USE   = 1'b1,
    parameter bit         LVD_ENABLE    = 1'b1
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_ext_reset_n,
    input  wire logic        i_lvd_low,
    input  wire logic        i_tone_detect,
    input  wire logic        i_sat_position_in,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_band_select_out,
    output logic             o_polarization_out,
    output logic             o_sat_position_out,
    output logic             o_sat_position_oe_n,
    output logic             o_sat_position_pullup_en,
    output logic             o_switch_option_out,
    output logic             o_uncommitted_out_a,
    output logic             o_uncommitted_out_b,
    output logic             o_uncommitted_out_c,
    output logic             o_uncommitted_out_d,
    output logic             o_standby_out
);
    import somm_pkg::*;

    // ==========================================================
    // helpers
    // one-hot decode of a select value onto eight lines
    function automatic logic [7:0] one_hot8(input logic [2:0] sel);
        logic [7:0] v;
        v = 8'h00;
        v[sel] = 1'b1;
        return v;
    endfunction

    // pick the line at a wrapped position of the switch vector
    function automatic logic pick(input logic [7:0] s, input logic [3:0] idx);
        logic [2:0] w;
        w = idx[2:0];
        return s[w];
    endfunction

    // ==========================================================
    // internal reset sources
    // the external pin and the detector hold every register except the bus slave flops like a
    // synchronous clear to the same constants; only the async i_rst clears without an edge
    logic hold_reset;
    assign hold_reset = ~i_ext_reset_n
                      | (LVD_ENABLE & i_lvd_low);

    // ==========================================================
    // factory configuration, fixed at build time
    somm_cfg_s  cfg;
    somm_mode_e mode;
    logic       dec_selected;
    assign cfg          = somm_cfg_s'(OUTPUT_CONFIG[6:0]);
    assign dec_selected = (cfg.decoded_number != 4'h0);
    // decoded mode takes priority, so only one mode is ever live
    assign mode = dec_selected      ? MODE_DECODED :
                  cfg.complementary ? MODE_COMPLEMENTARY :
                                      MODE_SINGLE;

    // ==========================================================
    // registers
    logic [7:0]  switch_reg;
    logic [7:0]  switch_next;
    logic [1:0]  control_reg;
    logic [1:0]  control_next;
    logic        pos_drive_reg;
    logic        pos_drive_next;
    logic [7:0]  out_reg;
    logic [7:0]  out_next;
    logic        standby_reg;
    logic        standby_next;
    logic        pos_oe_n_reg;
    logic        pullup_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        pslverr_next;

    // ==========================================================
    // apb decode
    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic hit_switch;
    logic hit_control;
    logic hit_config;
    logic hit_status;
    logic hit_pos_dir;
    logic hit_any;
    logic hit_writable;

    assign setup_phase  = i_psel & ~i_penable;
    assign access_done  = i_psel & i_penable & pready_reg;
    assign hit_switch   = (i_paddr == ADDR_SWITCH_STATE);
    assign hit_control  = (i_paddr == ADDR_CONTROL);
    assign hit_config   = (i_paddr == ADDR_CONFIG);
    assign hit_status   = (i_paddr == ADDR_STATUS);
    assign hit_pos_dir  = (i_paddr == ADDR_POS_DIR);
    assign hit_any      = hit_switch | hit_control | hit_config | hit_status | hit_pos_dir;
    assign hit_writable = hit_switch | hit_control | hit_pos_dir;
    // writes to read-only or unmapped words are dropped and flagged
    assign wr_en        = access_done & i_pwrite & hit_writable & ~pslverr_reg;

    assign switch_next    = (wr_en & hit_switch)  ? i_pwdata[7:0] : switch_reg;
    assign control_next   = (wr_en & hit_control) ? i_pwdata[1:0] : control_reg;
    assign pos_drive_next = (wr_en & hit_pos_dir) ? i_pwdata[0]   : pos_drive_reg;
    assign pslverr_next   = ~hit_any | (i_pwrite & (hit_config | hit_status));

    // ==========================================================
    // effective switch state
    // backward mode: the tone replaces one committed line
    somm_switch_s sw_eff;
    logic [7:0]   sw_vec;
    logic         backcompat;
    assign backcompat = control_reg[CTL_BACKCOMPAT];
    always_comb
    begin
        sw_eff = somm_switch_s'(switch_reg);
        if (backcompat)
        begin
            if (cfg.tone_use)
            begin
                sw_eff.position_b_a = i_tone_detect;
            end
            else
            begin
                sw_eff.band_high_low = i_tone_detect;
            end
        end
    end
    assign sw_vec = 8'(sw_eff);

    // ==========================================================
    // output mapping per mode
    logic [3:0] dec_start;
    logic [2:0] dec_sel3;
    logic [1:0] dec_sel2;
    logic [7:0] out_single;
    logic [7:0] out_decoded;
    logic [7:0] out_compl;
    logic [7:0] dec2_hot;

    // decoded number n picks lines n-1, n, n+1 (wrapping at eight)
    assign dec_start = cfg.decoded_number - 4'h1;
    assign dec_sel3  = {pick(sw_vec, dec_start + 4'h2),
                        pick(sw_vec, dec_start + 4'h1),
                        pick(sw_vec, dec_start)};
    assign dec_sel2  = {pick(sw_vec, dec_start + 4'h1),
                        pick(sw_vec, dec_start)};

    assign out_single = sw_vec;
    // two-line decode keeps the upper four outputs quiet
    assign dec2_hot    = one_hot8({1'b0, dec_sel2});
    assign out_decoded = cfg.two_line ? {4'h0, dec2_hot[3:0]}
                                      : one_hot8(dec_sel3);
    assign out_compl = {~sw_vec[COMMITTED-1:0], sw_vec[COMMITTED-1:0]};

    always_comb
    begin
        unique case (mode)
            MODE_DECODED:       out_next = out_decoded;
            MODE_COMPLEMENTARY: out_next = out_compl;
            MODE_SINGLE:        out_next = out_single;
            default:            out_next = RST_OUTPUTS;
        endcase
    end

    assign standby_next = STANDBY_USE & control_reg[CTL_STANDBY];

    // ==========================================================
    // read data
    logic [31:0] status_word;
    always_comb
    begin
        status_word = 32'h0;
        status_word[SW_COUNT-1:0] = out_reg;
        status_word[ST_STANDBY]   = standby_reg;
        status_word[ST_POS_DRV]   = pos_drive_reg;
        status_word[ST_POS_PIN]   = i_sat_position_in;
        status_word[ST_MODE_LSB+1:ST_MODE_LSB] = mode;
    end

    always_comb
    begin
        prdata_next = 32'h0;
        if (hit_switch)
        begin
            prdata_next[7:0] = switch_reg;
        end
        if (hit_control)
        begin
            prdata_next[1:0] = control_reg;
        end
        if (hit_config)
        begin
            prdata_next[7:0] = OUTPUT_CONFIG;
        end
        if (hit_status)
        begin
            prdata_next = status_word;
        end
        if (hit_pos_dir)
        begin
            prdata_next[0] = pos_drive_reg;
        end
    end

    // ==========================================================
    // bus slave flops: answer one cycle after setup
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end
        else
        begin
            pready_reg  <= setup_phase;
            pslverr_reg <= setup_phase & pslverr_next;
            prdata_reg  <= (setup_phase & ~i_pwrite) ? prdata_next : 32'h0;
        end
    end

    // ==========================================================
    // software-visible state
    // the pin and the detector clear like i_rst, but only on an edge,
    // so a short glitch on either cannot leave half the state cleared
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            switch_reg    <= RST_SWITCH_STATE;
            control_reg   <= RST_CONTROL;
            pos_drive_reg <= 1'b0;
        end
        else if (hold_reset)
        begin
            switch_reg    <= RST_SWITCH_STATE;
            control_reg   <= RST_CONTROL;
            pos_drive_reg <= 1'b0;
        end
        else
        begin
            switch_reg    <= switch_next;
            control_reg   <= control_next;
            pos_drive_reg <= pos_drive_next;
        end
    end

    // ==========================================================
    // mapped outputs and standby
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_reg     <= RST_OUTPUTS;
            standby_reg <= 1'b0;
        end
        else if (hold_reset)
        begin
            out_reg     <= RST_OUTPUTS;
            standby_reg <= 1'b0;
        end
        else
        begin
            out_reg     <= out_next;
            standby_reg <= standby_next;
        end
    end

    // ==========================================================
    // position pin direction
    // any reset leaves a pulled-up input, even after software drove it
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pos_oe_n_reg <= 1'b1;
            pullup_reg   <= 1'b1;
        end
        else if (hold_reset)
        begin
            pos_oe_n_reg <= 1'b1;
            pullup_reg   <= 1'b1;
        end
        else
        begin
            pos_oe_n_reg <= ~pos_drive_next;
            pullup_reg   <= ~pos_drive_next;
        end
    end

    // ==========================================================
    // pins
    assign o_band_select_out        = out_reg[SW_BAND];
    assign o_polarization_out       = out_reg[SW_POL];
    assign o_sat_position_out       = out_reg[SW_POS];
    assign o_switch_option_out      = out_reg[SW_OPTION];
    assign o_uncommitted_out_a      = out_reg[4];
    assign o_uncommitted_out_b      = out_reg[5];
    assign o_uncommitted_out_c      = out_reg[6];
    assign o_uncommitted_out_d      = out_reg[7];
    assign o_standby_out            = standby_reg;
    assign o_sat_position_oe_n      = pos_oe_n_reg;
    assign o_sat_position_pullup_en = pullup_reg;
    assign o_prdata                 = prdata_reg;
    assign o_pready                 = pready_reg;
    assign o_pslverr                = pslverr_reg;

endmodule // somm_output_mapper

/* File: tb/somm_switch_partner.sv */
`timescale 1ns/1ps

// ==========================================
// sat position wire seen by the switcher
module somm_switch_partner
(
    input  wire logic i_mclk,
    input  wire logic i_pos_out,
    input  wire logic i_pos_oe_n,
    input  wire logic i_pos_pullup_en,
    output logic      o_pos_level
);
    logic float_reg = 1'b0;
    // a floating wire toggles so a stale value can never pass for a drive
    always @(posedge i_mclk)
    begin
        float_reg <= ~float_reg;
    end
    assign o_pos_level = !i_pos_oe_n ? i_pos_out : (i_pos_pullup_en ? 1'b1 : float_reg);
endmodule // somm_switch_partner

/* File: tb/somm_output_mapper_properties.sv */
`timescale 1ns/1ps

// ==========================================
// port checker
module somm_output_mapper_properties
    import somm_pkg::*;
#(
    parameter logic [7:0] OUTPUT_CONFIG = CFG_DEFAULT,
    parameter bit         LVD_ENABLE    = 1'b1
)
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_ext_reset_n,
    input wire logic        i_lvd_low,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_band_select_out,
    input wire logic        o_polarization_out,
    input wire logic        o_sat_position_out,
    input wire logic        o_sat_position_oe_n,
    input wire logic        o_sat_position_pullup_en,
    input wire logic        o_switch_option_out,
    input wire logic        o_uncommitted_out_a,
    input wire logic        o_uncommitted_out_b,
    input wire logic        o_uncommitted_out_c,
    input wire logic        o_uncommitted_out_d,
    input wire logic        o_standby_out
);
    localparam bit DEC = OUTPUT_CONFIG[4:1] != 4'h0;
    localparam bit COMPL = !DEC && OUTPUT_CONFIG[5];
    localparam logic [1:0] MODE = DEC ? 2'h1 : (OUTPUT_CONFIG[5] ? 2'h2 : 2'h0);
    wire [7:0] pins = {o_uncommitted_out_d, o_uncommitted_out_c, o_uncommitted_out_b, o_uncommitted_out_a,
                       o_switch_option_out, o_sat_position_out, o_polarization_out, o_band_select_out};
    wire clr = !i_ext_reset_n || (i_lvd_low && LVD_ENABLE);
    wire rd_setup = i_psel && !i_penable && !i_pwrite;
    // cycles since the last clear; outputs are trusted only once it saturates
    logic [1:0] run_cnt;
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst) run_cnt <= 2'h0;
        else if (clr) run_cnt <= 2'h0;
        else if (run_cnt != 2'h3) run_cnt <= run_cnt + 2'h1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_ext_clear: assert property (!i_ext_reset_n |=> pins == 8'h00 && !o_standby_out)
        else $error("outputs not cleared by external reset");
    a_lvd_clear: assert property (i_lvd_low && LVD_ENABLE |=> pins == 8'h00 && !o_standby_out)
        else $error("outputs not cleared by low supply");
    a_pos_revert: assert property (!i_ext_reset_n |=> o_sat_position_oe_n && o_sat_position_pullup_en)
        else $error("position pin not back to pulled-up input");
    a_pos_pullup: assert property (o_sat_position_oe_n |-> o_sat_position_pullup_en)
        else $error("position input without pull-up");
    a_dec_onehot: assert property (DEC && run_cnt == 2'h3 |-> $onehot(pins))
        else $error("decoded outputs not one-hot");
    a_config_read: assert property (rd_setup && i_paddr == ADDR_CONFIG |=> o_prdata == {24'h0, OUTPUT_CONFIG})
        else $error("config read differs from factory value");
    a_cfg_refused: assert property (i_psel && !i_penable && i_pwrite && (i_paddr == ADDR_CONFIG ||
        i_paddr == ADDR_STATUS) |=> o_pready && o_pslverr)
        else $error("read-only write not refused");
    a_mode_status: assert property (rd_setup && i_paddr == ADDR_STATUS |=> o_prdata[12:11] == MODE)
        else $error("mode field wrong");
    a_compl_inverse: assert property (COMPL && run_cnt == 2'h3 |-> pins[7:4] == ~pins[3:0])
        else $error("uncommitted outputs not inverse of committed");
endmodule // somm_output_mapper_properties

bind somm_output_mapper somm_output_mapper_properties #(.OUTPUT_CONFIG(OUTPUT_CONFIG), .LVD_ENABLE(LVD_ENABLE))
    chk_u (.*);

/* File: tb/tb_switch_output_mode_mapper.sv */
`timescale 1ns/1ps

// ==========================================
// bench top
module tb_switch_output_mode_mapper;
    import somm_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_ext_reset_n = 1'b1, i_lvd_low = 1'b0, i_tone_detect = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00, sw;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic o_pready, o_pslverr, o_band_select_out, o_polarization_out, o_sat_position_out, o_sat_position_oe_n;
    logic o_sat_position_pullup_en, o_switch_option_out, o_uncommitted_out_a, o_uncommitted_out_b;
    logic o_uncommitted_out_c, o_uncommitted_out_d, o_standby_out, i_sat_position_in;
    logic [32:0] exp_q[$];
    int bad_count = 0, compares = 0, i, k;
    wire [7:0] pins = {o_uncommitted_out_d, o_uncommitted_out_c, o_uncommitted_out_b, o_uncommitted_out_a,
                       o_switch_option_out, o_sat_position_out, o_polarization_out, o_band_select_out};
    wire [7:0] pins_s, pins_c, pins_t;
    always #2 i_mclk = ~i_mclk;
    somm_output_mapper dut_u (.*);
    somm_switch_partner far_u (.i_mclk(i_mclk), .i_pos_out(o_sat_position_out), .i_pos_oe_n(o_sat_position_oe_n),
        .i_pos_pullup_en(o_sat_position_pullup_en), .o_pos_level(i_sat_position_in));
    // one more instance per factory mode on the same bus; only their pins are compared
    // single polarity, tone on position
    somm_output_mapper #(.OUTPUT_CONFIG(8'h01)) dut_single (.*, .o_prdata(), .o_pready(), .o_pslverr(),
        .o_band_select_out(pins_s[0]), .o_polarization_out(pins_s[1]), .o_sat_position_out(pins_s[2]),
        .o_switch_option_out(pins_s[3]), .o_uncommitted_out_a(pins_s[4]), .o_uncommitted_out_b(pins_s[5]),
        .o_uncommitted_out_c(pins_s[6]), .o_uncommitted_out_d(pins_s[7]), .o_sat_position_oe_n(),
        .o_sat_position_pullup_en(), .o_standby_out());
    // complementary, tone on band
    somm_output_mapper #(.OUTPUT_CONFIG(8'h20)) dut_compl (.*, .o_prdata(), .o_pready(), .o_pslverr(),
        .o_band_select_out(pins_c[0]), .o_polarization_out(pins_c[1]), .o_sat_position_out(pins_c[2]),
        .o_switch_option_out(pins_c[3]), .o_uncommitted_out_a(pins_c[4]), .o_uncommitted_out_b(pins_c[5]),
        .o_uncommitted_out_c(pins_c[6]), .o_uncommitted_out_d(pins_c[7]), .o_sat_position_oe_n(),
        .o_sat_position_pullup_en(), .o_standby_out());
    // two-line decode of position and option
    somm_output_mapper #(.OUTPUT_CONFIG(8'h46)) dut_two (.*, .o_prdata(), .o_pready(), .o_pslverr(),
        .o_band_select_out(pins_t[0]), .o_polarization_out(pins_t[1]), .o_sat_position_out(pins_t[2]),
        .o_switch_option_out(pins_t[3]), .o_uncommitted_out_a(pins_t[4]), .o_uncommitted_out_b(pins_t[5]),
        .o_uncommitted_out_c(pins_t[6]), .o_uncommitted_out_d(pins_t[7]), .o_sat_position_oe_n(),
        .o_sat_position_pullup_en(), .o_standby_out());
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // every transfer notes {pslverr, prdata}; the monitor compares it
    task apb(input int wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
        int n;
        @(posedge i_mclk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, (wr != 0), a, d};
        exp_q.push_back(exp);
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1)
        begin
            bad_count++;
            test_done();
        end
        {i_psel, i_penable} <= 2'b00;
    endtask
    always @(posedge i_mclk)
    begin
        if (i_psel && i_penable && o_pready === 1'b1 && exp_q.size() > 0)
            check("apb", {o_pslverr, o_prdata}, exp_q.pop_front());
    end
    initial
    begin
        void'($urandom(32'h614c));
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        apb(0, ADDR_CONFIG, 0, {25'h0, CFG_DEFAULT});
        apb(0, ADDR_CONTROL, 0, 33'h1);
        apb(0, ADDR_POS_DIR, 0, 33'h0);
        apb(0, ADDR_STATUS, 0, 33'hc01);
        $display("test reset values done");
        for (i = 0; i < 16; i++)
        begin
            sw = 8'($urandom);
            i_tone_detect <= 1'($urandom);
            apb(1, ADDR_SWITCH_STATE, {24'h0, sw}, 33'h0);
            apb(0, ADDR_SWITCH_STATE, 0, {25'h0, sw});
            // lines four to six select, lsb first
            apb(0, ADDR_STATUS, 0, {17'h0, 8'h0c, 8'h01 << sw[6:4]});
            check("pins", {25'h0, pins}, {25'h0, 8'h01 << sw[6:4]});
            check("single", {25'h0, pins_s}, {25'h0, sw[7:3], i_tone_detect, sw[1:0]});
            check("compl", {25'h0, pins_c}, {25'h0, ~sw[3:1], ~i_tone_detect, sw[3:1], i_tone_detect});
            check("two line", {25'h0, pins_t}, {25'h0, 4'h0, 4'h1 << sw[3:2]});
        end
        $display("test decoded mapping done");
        apb(1, ADDR_CONFIG, 32'hff, 33'h100000000);
        apb(1, ADDR_STATUS, 32'hff, 33'h100000000);
        apb(0, 8'h14, 0, 33'h100000000);
        apb(0, ADDR_CONFIG, 0, {25'h0, CFG_DEFAULT});
        $display("test refusals done");
        apb(1, ADDR_CONTROL, 32'h3, 33'h0);
        apb(1, ADDR_POS_DIR, 32'h1, 33'h0);
        apb(1, ADDR_SWITCH_STATE, 32'h0, 33'h0);
        apb(0, ADDR_STATUS, 0, 33'hb01);
        check("standby", {32'h0, o_standby_out}, 33'h1);
        check("pos oe_n", {32'h0, o_sat_position_oe_n}, 33'h0);
        $display("test standby and drive done");
        for (k = 0; k < 2; k++)
        begin
            @(posedge i_mclk);
            if (k == 0) i_ext_reset_n <= 1'b0;
            else i_lvd_low <= 1'b1;
            repeat (2) @(posedge i_mclk);
            check("cleared", {22'h0, pins, o_standby_out, o_sat_position_oe_n, o_sat_position_pullup_en},
                  33'h3);
            {i_ext_reset_n, i_lvd_low} <= 2'b10;
            repeat (3) @(posedge i_mclk);
            check("redriven", {25'h0, pins}, 33'h1);
            apb(0, ADDR_POS_DIR, 0, 33'h0);
        end
        $display("test resets done");
        test_done();
    end
endmodule // tb_switch_output_mode_mapper
